// file: hdl/etm_pkg.sv
// Constants, register map and encodings of the event-triggered timer
package etm_pkg;

  // ==========================================================
  // Register bus
  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  localparam logic [5:0] ADDR_CTRL_A = 6'h00;
  localparam logic [5:0] ADDR_CONTROL_B = 6'h04;
  localparam logic [5:0] ADDR_EVENT_CONTROL = 6'h08;
  localparam logic [5:0] ADDR_INT_ENABLE = 6'h0c;
  localparam logic [5:0] ADDR_INT_STATUS = 6'h10;
  localparam logic [5:0] ADDR_INT_CLEAR = 6'h14;
  localparam logic [5:0] ADDR_STATUS = 6'h18;
  localparam logic [5:0] ADDR_COUNT = 6'h1c;
  localparam logic [5:0] ADDR_COMPARE = 6'h20;

  // ==========================================================
  // Field positions
  localparam int CTRL_A_ENABLE_BIT = 0;
  localparam int CB_MODE_LSB = 0;
  localparam int CB_MODE_W = 3;
  localparam int CB_EVENT_RESPONSE_A_BIT = 6;
  localparam int EV_CAPT_BIT = 0;
  localparam int EV_EDGE_BIT = 4;
  localparam int STATUS_RUN_BIT = 0;
  localparam int INT_CAPT_BIT = 0;
  localparam int INT_DONE_BIT = 1;
  localparam int INT_W = 2;
  localparam int CNT_W = 16;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CONTROL_B_RST = 8'h00;
  localparam logic [7:0] EVENT_CONTROL_RST = 8'h00;
  localparam logic [1:0] INT_RST = 2'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP = 16'hffff;

  // ==========================================================
  // Timing: counter_clock derived from the peripheral clock
  localparam int PERIPHERAL_CLOCK_NS = 50;
  localparam int CNT_CLK_NS = 100;
  localparam int DIV_W = 4;
  localparam logic [3:0] CNT_DIV = 4'(CNT_CLK_NS / PERIPHERAL_CLOCK_NS);

  // ==========================================================
  // Encodings
  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT = 3'h1,
    MODE_CAPT = 3'h2,
    MODE_FREQ = 3'h3,
    MODE_PW = 3'h4,
    MODE_FRQPW = 3'h5,
    MODE_SINGLE = 3'h6,
    MODE_PWM8 = 3'h7
  } etm_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_HOLD = 2'h2
  } etm_state_e;

  typedef enum logic [1:0] {
    PH_WAIT = 2'h0,
    PH_HIGH = 2'h1,
    PH_LOW = 2'h2
  } etm_phase_e;

endpackage

// file: hdl/etm_timer.sv
// Event-triggered 16-bit timer with Avalon-MM registers
// What this block does
// - Single-shot: a qualifying edge while stopped gives one pulse of compare_value + 1 counter_clock ticks.
// - Single-shot, counter stopped: waveform output held low unless event_response_a sets it on an edge.
// - Trigger clears the count, counts up from bottom, output high meanwhile.
// - Status bit counter_running shows whether the counter is counting.
// - On compare match: stop, low for a counter_clock tick, events ignored.
// - New trigger raises output exactly two peripheral_clock cycles later.
// - Edge select 1: either edge starts; edge select 0: rising edges only.
// - Enable or edge-select change self-starts; top in count prevents it.
// - Switching to single-shot with edge select 1 while enabled self-starts too; top in count prevents it.
// - event_response_a: edge sets output now; count starts two cycles later.
// - Inactive edges, both edges in periodic mode included, are ignored.
// - Timeout check: selected edge starts counter, opposite edge stops it.
// - Capture mode: selected edge captures and interrupts; other ignored.
// - Frequency: selected edge captures, clears, restarts and interrupts.
// - Pulse width: selected edge restarts; opposite captures and interrupts.
// - Frequency and width: clear, then capture, then stop and interrupt.
`timescale 1ns/100ps
module etm_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic event_in,
  output logic wave_out,
  output logic irq
);

  // ==========================================================
  // Register bus slave
  logic [7:0] ctrl_a_reg, ctrl_a_next;
  logic [7:0] control_b_reg, control_b_next;
  logic [7:0] event_control_reg, event_control_next;
  logic [1:0] int_enable_reg, int_enable_next;
  logic [1:0] int_status_reg, int_status_next;
  logic rd_done_reg, rd_done_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] compare_reg, compare_next;
  logic run_reg, run_next;
  logic wave_reg, wave_next;
  logic capt_set, done_set;
  logic wr_count, wr_compare;
  logic [15:0] wdata16;

  logic en, edge_sel, event_response_a_en, capt_en;
  etm_pkg::etm_mode_e mode;
  assign en = ctrl_a_reg[etm_pkg::CTRL_A_ENABLE_BIT];
  assign mode = etm_pkg::etm_mode_e'(control_b_reg[etm_pkg::CB_MODE_LSB +:
                                          etm_pkg::CB_MODE_W]);
  assign event_response_a_en = control_b_reg[etm_pkg::CB_EVENT_RESPONSE_A_BIT];
  assign edge_sel = event_control_reg[etm_pkg::EV_EDGE_BIT];
  assign capt_en = event_control_reg[etm_pkg::EV_CAPT_BIT];

  // Reads take one wait cycle so read data always comes from a flop
  assign avs_waitrequest = avs_read && !rd_done_reg;
  assign avs_readdata = rdata_reg;
  assign wr_count = avs_write && (avs_address == etm_pkg::ADDR_COUNT);
  assign wr_compare = avs_write && (avs_address == etm_pkg::ADDR_COMPARE);
  assign wdata16 = avs_writedata[15:0];

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    control_b_next = control_b_reg;
    event_control_next = event_control_reg;
    int_enable_next = int_enable_reg;
    int_status_next = int_status_reg;
    rd_done_next = avs_read && !rd_done_reg;
    rdata_next = rdata_reg;
    if (avs_write && avs_byteenable[0]) begin
      unique case (avs_address)
        etm_pkg::ADDR_CTRL_A: ctrl_a_next = avs_writedata[7:0];
        etm_pkg::ADDR_CONTROL_B: control_b_next = avs_writedata[7:0];
        etm_pkg::ADDR_EVENT_CONTROL: event_control_next = avs_writedata[7:0];
        etm_pkg::ADDR_INT_ENABLE: int_enable_next = avs_writedata[1:0];
        etm_pkg::ADDR_INT_CLEAR:
          int_status_next = int_status_reg & ~avs_writedata[1:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle
    int_status_next[etm_pkg::INT_CAPT_BIT] =
      int_status_next[etm_pkg::INT_CAPT_BIT] | capt_set;
    int_status_next[etm_pkg::INT_DONE_BIT] =
      int_status_next[etm_pkg::INT_DONE_BIT] | done_set;
    if (avs_read && !rd_done_reg) begin
      unique case (avs_address)
        etm_pkg::ADDR_CTRL_A: rdata_next = {24'h000000, ctrl_a_reg};
        etm_pkg::ADDR_CONTROL_B: rdata_next = {24'h000000, control_b_reg};
        etm_pkg::ADDR_EVENT_CONTROL:
          rdata_next = {24'h000000, event_control_reg};
        etm_pkg::ADDR_INT_ENABLE: rdata_next = {30'h00000000, int_enable_reg};
        etm_pkg::ADDR_INT_STATUS: rdata_next = {30'h00000000, int_status_reg};
        etm_pkg::ADDR_STATUS: rdata_next = {31'h00000000, run_reg};
        etm_pkg::ADDR_COUNT: rdata_next = {16'h0000, count_reg};
        etm_pkg::ADDR_COMPARE: rdata_next = {16'h0000, compare_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_reg <= etm_pkg::CTRL_A_RST;
      control_b_reg <= etm_pkg::CONTROL_B_RST;
      event_control_reg <= etm_pkg::EVENT_CONTROL_RST;
      int_enable_reg <= etm_pkg::INT_RST;
      int_status_reg <= etm_pkg::INT_RST;
      rd_done_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      control_b_reg <= control_b_next;
      event_control_reg <= event_control_next;
      int_enable_reg <= int_enable_next;
      int_status_reg <= int_status_next;
      rd_done_reg <= rd_done_next;
      rdata_reg <= rdata_next;
    end
  end

  assign irq = |(int_status_reg & int_enable_reg);

  // ==========================================================
  // Event synchroniser, edge detect and counter_clock divider
  logic ev_s1, ev_s2, ev_s3;
  logic [3:0] div_reg, div_next;
  logic cnt_tick, pos_ev, neg_ev, go_ev, stop_ev, ss_trig;

  always_comb begin
    div_next = 4'h0;
    if (en && div_reg != etm_pkg::CNT_DIV - 4'h1) begin
      div_next = div_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
      div_reg <= 4'h0;
    end else begin
      ev_s1 <= event_in;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      div_reg <= div_next;
    end
  end

  assign cnt_tick = en && (div_reg == etm_pkg::CNT_DIV - 4'h1);
  assign pos_ev = en && capt_en && ev_s2 && !ev_s3;
  assign neg_ev = en && capt_en && !ev_s2 && ev_s3;
  assign go_ev = edge_sel ? neg_ev : pos_ev;
  assign stop_ev = edge_sel ? pos_ev : neg_ev;
  assign ss_trig = pos_ev || (edge_sel && neg_ev);

  // ==========================================================
  // Timer core
  etm_pkg::etm_state_e state_reg, state_next;
  etm_pkg::etm_phase_e phase_reg, phase_next;
  logic en_q, edge_q, ss_q, self_start, ss_mode, match;

  assign ss_mode = (mode == etm_pkg::MODE_SINGLE);
  assign match = (count_reg == compare_reg);
  // Self-start quirk kept on purpose; top in the count masks it
  assign self_start = ss_mode && en && (count_reg != etm_pkg::TOP) &&
    (!en_q || (edge_sel != edge_q) || (!ss_q && edge_sel));

  always_comb begin
    state_next = etm_pkg::ST_IDLE;
    phase_next = phase_reg;
    count_next = count_reg;
    compare_next = compare_reg;
    run_next = run_reg;
    wave_next = 1'b0;
    capt_set = 1'b0;
    done_set = 1'b0;
    if (cnt_tick && run_reg) begin
      count_next = count_reg + 16'h0001;
    end
    if (!en) begin
      run_next = 1'b0;
      phase_next = etm_pkg::PH_WAIT;
    end else begin
      unique case (mode)
        etm_pkg::MODE_PERIODIC, etm_pkg::MODE_PWM8: begin
          // Events never reach this mode
          run_next = 1'b1;
          if (cnt_tick && match) begin
            count_next = etm_pkg::BOTTOM;
            capt_set = 1'b1;
          end
        end
        etm_pkg::MODE_TIMEOUT: begin
          if (go_ev) begin
            run_next = 1'b1;
            count_next = etm_pkg::BOTTOM;
          end else if (stop_ev) begin
            run_next = 1'b0;
          end
          if (run_reg && cnt_tick && match) begin
            capt_set = 1'b1;
          end
        end
        etm_pkg::MODE_CAPT: begin
          run_next = 1'b1;
          if (go_ev) begin
            compare_next = count_reg;
            capt_set = 1'b1;
          end
        end
        etm_pkg::MODE_FREQ: begin
          run_next = 1'b1;
          if (go_ev) begin
            compare_next = count_reg;
            count_next = etm_pkg::BOTTOM;
            capt_set = 1'b1;
          end
        end
        etm_pkg::MODE_PW: begin
          run_next = 1'b1;
          if (go_ev) begin
            count_next = etm_pkg::BOTTOM;
          end else if (stop_ev) begin
            compare_next = count_reg;
            capt_set = 1'b1;
          end
        end
        etm_pkg::MODE_FRQPW: begin
          unique case (phase_reg)
            etm_pkg::PH_WAIT: if (go_ev) begin
              count_next = etm_pkg::BOTTOM;
              run_next = 1'b1;
              phase_next = etm_pkg::PH_HIGH;
            end
            etm_pkg::PH_HIGH: if (stop_ev) begin
              compare_next = count_reg;
              phase_next = etm_pkg::PH_LOW;
            end
            etm_pkg::PH_LOW: if (go_ev) begin
              run_next = 1'b0;
              capt_set = 1'b1;
              phase_next = etm_pkg::PH_WAIT;
            end
            default: phase_next = etm_pkg::PH_WAIT;
          endcase
        end
        etm_pkg::MODE_SINGLE: begin
          state_next = state_reg;
          unique case (state_reg)
            etm_pkg::ST_IDLE: begin
              run_next = 1'b0;
              if (ss_trig || self_start) begin
                state_next = etm_pkg::ST_RUN;
                run_next = 1'b1;
                wave_next = 1'b1;
                if (ss_trig) begin
                  count_next = etm_pkg::BOTTOM;
                end
              end
            end
            etm_pkg::ST_RUN: begin
              wave_next = 1'b1;
              if (cnt_tick && match) begin
                state_next = etm_pkg::ST_HOLD;
                run_next = 1'b0;
                wave_next = 1'b0;
                count_next = count_reg;
                done_set = 1'b1;
              end
            end
            etm_pkg::ST_HOLD: begin
              // Low until the next counter tick; events dropped meanwhile
              if (cnt_tick) begin
                state_next = etm_pkg::ST_IDLE;
              end
            end
            default: state_next = etm_pkg::ST_IDLE;
          endcase
        end
        default: ;
      endcase
    end
    if (mode != etm_pkg::MODE_FRQPW) begin
      phase_next = etm_pkg::PH_WAIT;
    end
    if (wr_count) begin
      count_next = merge16(count_reg, wdata16, avs_byteenable[1:0]);
    end
    if (wr_compare) begin
      compare_next = merge16(compare_reg, wdata16, avs_byteenable[1:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= etm_pkg::ST_IDLE;
      phase_reg <= etm_pkg::PH_WAIT;
      count_reg <= etm_pkg::COUNT_RST;
      compare_reg <= etm_pkg::COMPARE_RST;
      run_reg <= 1'b0;
      wave_reg <= 1'b0;
      en_q <= 1'b0;
      edge_q <= 1'b0;
      ss_q <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      count_reg <= count_next;
      compare_reg <= compare_next;
      run_reg <= run_next;
      wave_reg <= wave_next;
      en_q <= en;
      edge_q <= edge_sel;
      ss_q <= ss_mode;
    end
  end

  // Unsynchronised path: the pin sets the output and holds it until the
  // registered output takes over; event line glitches reach the pin too
  logic event_response_a_set;
  assign event_response_a_set = event_response_a_en && ss_mode && en && capt_en &&
    (state_reg == etm_pkg::ST_IDLE) && (event_in != ev_s3) &&
    (edge_sel || event_in);
  assign wave_out = wave_reg || event_response_a_set;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  ss_low_idle_a: assert property (
    ss_mode && state_reg == etm_pkg::ST_IDLE && !event_response_a_set |-> !wave_out)
    else $error("output high while single-shot is stopped");

  trig_start_a: assert property (
    ss_mode && en && state_reg == etm_pkg::ST_IDLE && ss_trig &&
    !avs_write |=> wave_reg && run_reg && count_reg == etm_pkg::BOTTOM)
    else $error("trigger did not clear and start the counter");

  run_read_a: assert property (
    avs_read && !rd_done_reg && avs_address == etm_pkg::ADDR_STATUS
    |=> !avs_waitrequest && avs_readdata[0] == $past(run_reg))
    else $error("status read does not show the running bit");

  match_stop_a: assert property (
    ss_mode && en && state_reg == etm_pkg::ST_RUN && cnt_tick && match
    |=> !wave_reg && !run_reg && state_reg == etm_pkg::ST_HOLD)
    else $error("compare match did not stop the pulse");

  hold_ignore_a: assert property (
    ss_mode && en && state_reg == etm_pkg::ST_HOLD && !cnt_tick
    |=> state_reg == etm_pkg::ST_HOLD && !run_reg)
    else $error("event accepted during the low interval");

  two_cycle_a: assert property (
    ss_mode && en && capt_en && !edge_sel && !event_response_a_en &&
    state_reg == etm_pkg::ST_IDLE && !ev_s2 && !ev_s3 && $rose(event_in)
    ##1 (state_reg == etm_pkg::ST_IDLE && ss_mode && en && capt_en &&
         !self_start)
    |-> !wave_reg ##1 !wave_reg ##1 wave_reg)
    else $error("output not raised two cycles after the event");

  edge_select_a: assert property (
    ss_mode && en && state_reg == etm_pkg::ST_IDLE && neg_ev &&
    !self_start |=> run_reg == edge_sel)
    else $error("falling edge handling disagrees with edge select");

  self_start_a: assert property (
    ss_mode && en && !en_q && state_reg == etm_pkg::ST_IDLE &&
    count_reg != etm_pkg::TOP |=> run_reg)
    else $error("single-shot did not self-start on enable");

  event_response_a_set_a: assert property (
    event_response_a_en && ss_mode && en && capt_en &&
    state_reg == etm_pkg::ST_IDLE &&
    ((event_in && !ev_s3) || (edge_sel && !event_in && ev_s3)) |-> wave_out)
    else $error("asynchronous event did not set the output");

  periodic_ign_a: assert property (
    mode == etm_pkg::MODE_PERIODIC && en && !cnt_tick && !wr_count
    && !wr_compare |=> $stable(count_reg) && $stable(compare_reg))
    else $error("event changed the counter in periodic mode");

  timeout_a: assert property (
    mode == etm_pkg::MODE_TIMEOUT && en && stop_ev |=> !run_reg)
    else $error("timeout stop edge did not stop the counter");

  capture_a: assert property (
    mode == etm_pkg::MODE_CAPT && en && go_ev && !wr_compare
    |=> compare_reg == $past(count_reg) &&
        int_status_reg[etm_pkg::INT_CAPT_BIT])
    else $error("capture on event missed");

  freq_a: assert property (
    mode == etm_pkg::MODE_FREQ && en && go_ev && !wr_count
    |=> count_reg == etm_pkg::BOTTOM)
    else $error("frequency edge did not clear the counter");

  pw_a: assert property (
    mode == etm_pkg::MODE_PW && en && stop_ev && !wr_compare
    |=> compare_reg == $past(count_reg))
    else $error("pulse-width capture missed");

  frqpw_a: assert property (
    mode == etm_pkg::MODE_FRQPW && en && phase_reg == etm_pkg::PH_LOW &&
    go_ev |=> !run_reg && int_status_reg[etm_pkg::INT_CAPT_BIT])
    else $error("second edge did not stop and interrupt");

  count_hold_a: assert property (
    !cnt_tick && !wr_count && !go_ev && !ss_trig |=> $stable(count_reg))
    else $error("counter moved without a counter tick");

  ss_pulse_c: cover property (
    state_reg == etm_pkg::ST_RUN ##[1:300] state_reg == etm_pkg::ST_HOLD);
  capt_irq_c: cover property (go_ev && mode == etm_pkg::MODE_CAPT ##1 irq);
  frqpw_c: cover property (phase_reg == etm_pkg::PH_LOW && go_ev);
  event_response_a_c: cover property (event_response_a_set && !wave_reg);

endmodule

// file: verif/etm_event_chan.sv
// Event channel source and waveform pin monitor for the timer bench
`timescale 1ns/100ps
module etm_event_chan (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wave_out,
  output logic event_in,
  output logic [15:0] pulse_len
);
  logic [15:0] run_len;

  initial event_in = 1'b0;

  // ==========================================================
  // Event level moves just after a rising edge, as channel logic does
  task automatic drive(input logic lvl);
    @(posedge ref_clk);
    event_in <= lvl;
  endtask

  // ==========================================================
  // Pulse length in peripheral clock cycles, latched as the pin falls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_len <= 16'h0000;
      pulse_len <= 16'h0000;
    end else if (wave_out) begin
      run_len <= run_len + 16'h0001;
    end else if (run_len != 16'h0000) begin
      pulse_len <= run_len;
      run_len <= 16'h0000;
    end
  end
endmodule

// file: verif/etm_timer_test.sv
// Self-checking bench for the event-triggered timer
`timescale 1ns/100ps
module etm_timer_test;
  logic ref_clk;
  logic rst_n;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic event_in;
  logic wave_out;
  logic irq;
  logic [15:0] pulse_len;
  int failures;
  int num_checks;
  // Per mode: start level for edge select 0, toggles, last-edge flag
  logic [2:0] md [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
  logic st [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  int ntog [5] = '{2, 2, 2, 2, 3};
  logic ex [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  etm_timer u_etm_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .event_in(event_in),
    .wave_out(wave_out),
    .irq(irq)
  );

  etm_event_chan u_etm_event_chan (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wave_out(wave_out),
    .event_in(event_in),
    .pulse_len(pulse_len)
  );

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Request held until a rising edge sees waitrequest low; values read
  // right after that edge are the ones the design saw there
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk(32'(n), w ? 32'h1 : 32'h2, "bus answer");
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    acc(1'b1, a, d, x);
  endtask

  task automatic rc(input logic [5:0] a, input logic [31:0] e,
                    input string m);
    logic [31:0] d;
    acc(1'b0, a, 32'h0, d);
    chk(d, e, m);
  endtask

  task automatic wait_low();
    int n;
    n = 0;
    while (wave_out !== 1'b0 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk(32'(n < 100), 32'h1, "pulse ends");
    cyc(2);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #1000000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  // ==========================================================
  // Tests
  initial begin
    logic lvl;
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    cyc(2);
    rst_n <= 1'b1;
    for (int a = 0; a <= 36; a += 4) rc(6'(a), 32'h0, "reset value");
    wr(6'h24, 32'hffffffff);
    wr(etm_pkg::ADDR_STATUS, 32'h1);
    wr(etm_pkg::ADDR_INT_STATUS, 32'h3);
    rc(6'h24, 32'h0, "unmapped");
    rc(etm_pkg::ADDR_STATUS, 32'h0, "status read-only");
    rc(etm_pkg::ADDR_INT_STATUS, 32'h0, "flags read-only");
    $display("test registers done");
    wr(etm_pkg::ADDR_COUNT, 32'hffff);
    wr(etm_pkg::ADDR_COMPARE, 32'h5);
    wr(etm_pkg::ADDR_CONTROL_B, 32'h6);
    wr(etm_pkg::ADDR_EVENT_CONTROL, 32'h1);
    wr(etm_pkg::ADDR_INT_ENABLE, 32'h2);
    wr(etm_pkg::ADDR_CTRL_A, 32'h1);
    cyc(4);
    rc(etm_pkg::ADDR_STATUS, 32'h0, "no self start");
    chk(wave_out, 1'b0, "idle low");
    u_etm_event_chan.drive(1'b1);
    cyc(2);
    @(negedge ref_clk);
    chk(wave_out, 1'b0, "sync delay");
    @(negedge ref_clk);
    chk(wave_out, 1'b1, "pulse start");
    rc(etm_pkg::ADDR_STATUS, 32'h1, "running");
    wait_low();
    // Six counter ticks at compare 5; divider phase trims up to one cycle
    chk(32'(pulse_len >= 16'h000b && pulse_len <= 16'h000c), 32'h1, "width");
    rc(etm_pkg::ADDR_COUNT, 32'h5, "stop at compare");
    rc(etm_pkg::ADDR_INT_STATUS, 32'h2, "done flag");
    chk(irq, 1'b1, "irq raised");
    wr(etm_pkg::ADDR_INT_ENABLE, 32'h0);
    @(negedge ref_clk);
    chk(irq, 1'b0, "irq masked");
    wr(etm_pkg::ADDR_INT_ENABLE, 32'h2);
    wr(etm_pkg::ADDR_INT_CLEAR, 32'h2);
    @(negedge ref_clk);
    chk(irq, 1'b0, "irq cleared");
    u_etm_event_chan.drive(1'b0);
    cyc(6);
    rc(etm_pkg::ADDR_STATUS, 32'h0, "falling ignored");
    wr(etm_pkg::ADDR_COUNT, 32'h0);
    wr(etm_pkg::ADDR_EVENT_CONTROL, 32'h11);
    cyc(2);
    rc(etm_pkg::ADDR_STATUS, 32'h1, "edge change start");
    cyc(30);
    rc(etm_pkg::ADDR_INT_STATUS, 32'h2, "self run done");
    wr(etm_pkg::ADDR_CTRL_A, 32'h0);
    wr(etm_pkg::ADDR_COUNT, 32'h0);
    wr(etm_pkg::ADDR_CTRL_A, 32'h1);
    rc(etm_pkg::ADDR_STATUS, 32'h1, "enable start");
    cyc(30);
    wr(etm_pkg::ADDR_INT_CLEAR, 32'h2);
    wr(etm_pkg::ADDR_COUNT, 32'hffff);
    u_etm_event_chan.drive(1'b1);
    cyc(4);
    chk(wave_out, 1'b1, "either edge");
    wait_low();
    wr(etm_pkg::ADDR_COUNT, 32'hffff);
    wr(etm_pkg::ADDR_CONTROL_B, 32'h46);
    wr(etm_pkg::ADDR_INT_CLEAR, 32'h2);
    u_etm_event_chan.drive(1'b0);
    @(negedge ref_clk);
    chk(wave_out, 1'b1, "event_response_a set");
    wait_low();
    rc(etm_pkg::ADDR_INT_STATUS, 32'h2, "event_response_a done");
    $display("test single shot done");
    wr(etm_pkg::ADDR_INT_ENABLE, 32'h1);
    for (int i = 0; i < 5; i++) for (int e = 0; e < 2; e++) begin
      wr(etm_pkg::ADDR_CTRL_A, 32'h0);
      wr(etm_pkg::ADDR_CONTROL_B, 32'(md[i]));
      wr(etm_pkg::ADDR_EVENT_CONTROL, 32'(e * 16 + 1));
      wr(etm_pkg::ADDR_COUNT, 32'h0);
      wr(etm_pkg::ADDR_COMPARE, 32'hffff);
      lvl = st[i] ^ e[0];
      u_etm_event_chan.drive(lvl);
      cyc(4);
      wr(etm_pkg::ADDR_INT_CLEAR, 32'h3);
      wr(etm_pkg::ADDR_CTRL_A, 32'h1);
      for (int t = 0; t < ntog[i]; t++) begin
        if (t == ntog[i] - 1)
          rc(etm_pkg::ADDR_INT_STATUS, 32'h0, "early flag");
        lvl = !lvl;
        u_etm_event_chan.drive(lvl);
        cyc(6);
      end
      rc(etm_pkg::ADDR_INT_STATUS, 32'(ex[i]), "flag");
      chk(irq, ex[i], "mode irq");
    end
    $display("test capture modes done");
    for (int e = 0; e < 2; e++) begin
      wr(etm_pkg::ADDR_CTRL_A, 32'h0);
      wr(etm_pkg::ADDR_CONTROL_B, 32'h1);
      wr(etm_pkg::ADDR_EVENT_CONTROL, 32'(e * 16 + 1));
      u_etm_event_chan.drive(e[0]);
      cyc(4);
      wr(etm_pkg::ADDR_CTRL_A, 32'h1);
      u_etm_event_chan.drive(!e[0]);
      cyc(6);
      rc(etm_pkg::ADDR_STATUS, 32'h1, "timeout start");
      u_etm_event_chan.drive(e[0]);
      cyc(6);
      rc(etm_pkg::ADDR_STATUS, 32'h0, "timeout stop");
    end
    $display("test timeout done");
    test_done();
  end
endmodule
